/* src/sbsr_top.sv */
`timescale 1ns/100ps
module sbsr_top #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] std_event,
  input wire logic queue_nonempty,
  input wire logic queue_single,
  input wire logic trig_summary,
  input wire logic user_summary,
  input wire logic oper_summary,
  input wire logic advisory_internal,
  input wire logic advisory_host,
  output logic srq,
  output logic [7:0] status_byte
);

  sbsr_pkg::sbsr_state_s s_q;
  sbsr_pkg::sbsr_state_s s_d;
  logic access;
  logic wr;
  logic rd;
  logic [ADDR_W-1:0] a12;
  logic [7:0] sesr_set;
  logic event_summary_flag;
  logic message_available_flag;
  logic advisory_message_flag;
  logic [7:0] live;
  logic [7:0] enabled_live;
  logic master_summary_flag;
  logic request_service_flag;
  logic rd_stbq;

  // Bus decode; access strobe lasts one cycle, registered ready adds one wait state
  assign access = psel & penable & ~s_q.pready;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign a12 = paddr;
  assign rd_stbq = rd & (a12 == sbsr_pkg::ADDR_STBQ);

  // Live summary bits
  always_comb begin
    sesr_set = s_q.sesr | std_event;
    event_summary_flag = |(s_q.sesr & s_q.ese);
    message_available_flag = queue_nonempty & ~s_q.avail_hide;
    advisory_message_flag = s_q.adv_ev;
    live = sbsr_pkg::BYTE_RST;
    live[sbsr_pkg::TRG_BIT] = trig_summary;
    live[sbsr_pkg::USR_BIT] = user_summary;
    live[sbsr_pkg::ADV_BIT] = advisory_message_flag;
    live[sbsr_pkg::AVAIL_BIT] = message_available_flag;
    live[sbsr_pkg::EVSUM_BIT] = event_summary_flag;
    live[sbsr_pkg::OPER_BIT] = oper_summary;
    enabled_live = live & s_q.sre & sbsr_pkg::SRC_MASK;
    master_summary_flag = |enabled_live;
    request_service_flag = s_q.req_svc;
  end

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.pready = access;
    s_d.pslverr = 1'b0;
    s_d.prdata = sbsr_pkg::WORD_ZERO;
    s_d.sesr = sesr_set;
    s_d.adv_ev = s_q.adv_ev | advisory_internal;
    // Request-service set while enabled summary present and none pends; poll clear wins over set
    if (master_summary_flag && !s_q.req_svc && !(rd && a12 == sbsr_pkg::ADDR_SPOLL)) begin
      s_d.req_svc = 1'b1;
    end
    if (!queue_nonempty) begin
      s_d.avail_hide = 1'b0;
    end
    if (rd) begin
      case (a12)
        sbsr_pkg::ADDR_STB, sbsr_pkg::ADDR_STBQ: begin
          s_d.prdata[7:0] = live;
          s_d.prdata[sbsr_pkg::REQ_BIT] = master_summary_flag;
          if (rd_stbq && queue_single) begin
            s_d.avail_hide = 1'b1;
          end
        end
        sbsr_pkg::ADDR_SPOLL: begin
          s_d.prdata[7:0] = live;
          s_d.prdata[sbsr_pkg::REQ_BIT] = request_service_flag;
          s_d.req_svc = master_summary_flag & ~request_service_flag;
        end
        sbsr_pkg::ADDR_SRE: begin
          s_d.prdata[7:0] = s_q.sre & sbsr_pkg::SRE_WMASK;
        end
        sbsr_pkg::ADDR_SESR: begin
          s_d.prdata[7:0] = s_q.sesr;
          s_d.sesr = std_event; // Read clears, new events win
        end
        sbsr_pkg::ADDR_ESE: begin
          s_d.prdata[7:0] = s_q.ese;
        end
        sbsr_pkg::ADDR_ADVEV: begin
          s_d.prdata[0] = s_q.adv_ev;
          s_d.adv_ev = advisory_internal;
        end
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    if (wr) begin
      case (a12)
        sbsr_pkg::ADDR_SRE: begin
          s_d.sre = pwdata[7:0] & sbsr_pkg::SRE_WMASK;
        end
        sbsr_pkg::ADDR_ESE: begin
          s_d.ese = pwdata[7:0];
        end
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    s_d.srq = s_d.req_svc;
    s_d.stb = live;
    s_d.stb[sbsr_pkg::REQ_BIT] = s_d.req_svc;
  end

  // State register, cleared at reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign srq = s_q.srq;
  assign status_byte = s_q.stb;

  // Serial poll decode, shared by the request checks
  logic spoll_rd;
  assign spoll_rd = rd && a12 == sbsr_pkg::ADDR_SPOLL;

  // Poll that meets a pending request
  sequence poll_of_pending_seq;
    spoll_rd && s_q.req_svc;
  endsequence

  // Enabled summary present while no request pends
  sequence enabled_summary_seq;
    master_summary_flag && !s_q.req_svc && !spoll_rd;
  endsequence

  // Poll answer: flag gone, old flag shown in bit 6
  sequence poll_answer_seq;
    !s_q.req_svc ##0 prdata[sbsr_pkg::REQ_BIT];
  endsequence

  // Poll clears, enabled summary still there next cycle
  sequence rearm_seq;
    poll_of_pending_seq ##1 enabled_summary_seq;
  endsequence

  // Service request pin mirrors the flag
  srq_follows_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    srq == s_q.req_svc) else $error("srq differs from request flag");

  // Request flag rises on enabled summary
  req_sets_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    enabled_summary_seq |=> s_q.req_svc)
    else $error("request flag not set");

  // Request flag holds until a poll
  req_holds_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_q.req_svc && !spoll_rd) |=> s_q.req_svc) else $error("request flag dropped without poll");

  // Poll returns and clears the flag
  poll_clears_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    poll_of_pending_seq |=> poll_answer_seq)
    else $error("poll did not clear request flag");

  // Fresh request after a poll
  fresh_req_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    rearm_seq |=> s_q.req_svc)
    else $error("no fresh request after poll");

  // Status query leaves the flag alone
  query_keeps_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rd && a12 == sbsr_pkg::ADDR_STB && s_q.req_svc) |=> s_q.req_svc)
    else $error("status query disturbed request flag");

  // Status query shows master summary in bit 6
  query_bit6_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rd && a12 == sbsr_pkg::ADDR_STB) |=>
    (prdata[sbsr_pkg::REQ_BIT] == $past(master_summary_flag)))
    else $error("status query bit 6 wrong");

  // Status query weights by position, upper bits zero
  query_weights_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rd && a12 == sbsr_pkg::ADDR_STB) |=>
    ((prdata[7:0] & sbsr_pkg::SRC_MASK) == ($past(live) & sbsr_pkg::SRC_MASK))
    && (prdata[31:8] == 24'h000000)) else $error("status query weights wrong");

  // No enable, no summary
  no_enable_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_q.sre == 8'h00) |-> !master_summary_flag) else $error("summary without enable");

  // Enable bit 6 never stored
  sre_bit6_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !s_q.sre[sbsr_pkg::REQ_BIT]) else $error("enable bit 6 stored");

  // Enable write lands masked
  sre_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wr && a12 == sbsr_pkg::ADDR_SRE) |=>
    (s_q.sre == ($past(pwdata[7:0]) & sbsr_pkg::SRE_WMASK)))
    else $error("enable write lost");

  // Enable readback shows bit 6 clear
  sre_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rd && a12 == sbsr_pkg::ADDR_SRE) |=> !prdata[sbsr_pkg::REQ_BIT])
    else $error("enable readback bit 6 set");

  // Event enable write lands whole
  ese_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wr && a12 == sbsr_pkg::ADDR_ESE) |=> (s_q.ese == $past(pwdata[7:0])))
    else $error("event enable write lost");

  // Event summary is the masked OR
  evsum_live_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    event_summary_flag == |(s_q.sesr & s_q.ese)) else $error("event summary wrong");

  // Queue content shows as message available
  avail_live_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (queue_nonempty && !s_q.avail_hide) |-> live[sbsr_pkg::AVAIL_BIT])
    else $error("message available missing");

  // Reading the last queued reply hides bit 4
  avail_hide_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rd_stbq && queue_single) |=> !live[sbsr_pkg::AVAIL_BIT])
    else $error("message available not hidden");

  // Status byte output follows live sources
  stb_live_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    1'b1 |=> (status_byte[sbsr_pkg::OPER_BIT] == $past(oper_summary))
    && (status_byte[sbsr_pkg::TRG_BIT] == $past(trig_summary)))
    else $error("status byte not live");

  // Events latch whether enabled or not
  sesr_sets_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (std_event != 8'h00) |=> ((s_q.sesr & $past(std_event)) == $past(std_event)))
    else $error("event bit not set");

  // Event register read clears, new events kept
  sesr_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rd && a12 == sbsr_pkg::ADDR_SESR) |=> (s_q.sesr == $past(std_event)))
    else $error("event register read did not clear");

  // Advisory flag only from internal messages
  adv_quiet_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!s_q.adv_ev && !advisory_internal && !rd) |=> !s_q.adv_ev)
    else $error("advisory flag set without internal message");

  // Host display message ignored
  adv_host_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (advisory_host && !advisory_internal && !s_q.adv_ev) |=> !s_q.adv_ev)
    else $error("host message set advisory flag");

  // Internal message sets advisory flag
  adv_internal_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    advisory_internal |=> s_q.adv_ev) else $error("internal message missed");

  // Advisory event read clears it
  adv_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rd && a12 == sbsr_pkg::ADDR_ADVEV && !advisory_internal) |=> !s_q.adv_ev)
    else $error("advisory read did not clear");

  // Ready is a one-cycle pulse
  pready_pulse_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    pready |=> !pready) else $error("ready held too long");

  // Error only with ready
  err_with_ready_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    pslverr |-> pready) else $error("error without ready");

  // Writes outside the enable registers refused
  write_refused_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wr && a12 != sbsr_pkg::ADDR_SRE && a12 != sbsr_pkg::ADDR_ESE) |=> pslverr)
    else $error("refused write not flagged");

  // Nothing pending just after reset
  reset_clear_a: assert property (@(posedge ref_clk)
    $rose(nrst) |-> (!srq && status_byte == 8'h00))
    else $error("request pending after reset");

endmodule // sbsr_top

/* src/sbsr_pkg.sv */
package sbsr_pkg;
  // Status byte bit positions
  localparam int unsigned TRG_BIT = 1;
  localparam int unsigned USR_BIT = 2;
  localparam int unsigned ADV_BIT = 3;
  localparam int unsigned AVAIL_BIT = 4;
  localparam int unsigned EVSUM_BIT = 5;
  localparam int unsigned REQ_BIT = 6;
  localparam int unsigned OPER_BIT = 7;
  // Register byte addresses
  localparam logic [11:0] ADDR_STB = 12'h000;
  localparam logic [11:0] ADDR_SPOLL = 12'h004;
  localparam logic [11:0] ADDR_SRE = 12'h008;
  localparam logic [11:0] ADDR_SESR = 12'h00C;
  localparam logic [11:0] ADDR_ESE = 12'h010;
  localparam logic [11:0] ADDR_ADVEV = 12'h014;
  localparam logic [11:0] ADDR_STBQ = 12'h018;
  // Zero values and register masks
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] SRE_WMASK = 8'hBF;
  localparam logic [7:0] SRC_MASK = 8'hBF;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] sre;
    logic [7:0] ese;
    logic [7:0] sesr;
    logic req_svc;
    logic adv_ev;
    logic avail_hide;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic srq;
    logic [7:0] stb;
  } sbsr_state_s;
endpackage

/* sim/sbsr_queue_model.sv */
`timescale 1ns/100ps
// Output queue model; counts waiting messages
module sbsr_queue_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic push,
  input wire logic pop,
  output logic queue_nonempty,
  output logic queue_single
);
  logic [3:0] cnt_q;
  // Queue empties on power-on
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) cnt_q <= 4'h0;
    else cnt_q <= cnt_q + 4'(push) - 4'(pop && cnt_q != 4'h0);
  end
  // Levels toward the status logic
  assign queue_nonempty = cnt_q != 4'h0;
  assign queue_single = cnt_q == 4'h1;
endmodule // sbsr_queue_model

/* sim/status_byte_service_request_tb_top.sv */
`timescale 1ns/100ps
module status_byte_service_request_tb_top;
  logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, srq, qne, qs, push = 1'b0, pop = 1'b0;
  logic trg = 1'b0, usr = 1'b0, opr = 1'b0, ai = 1'b0, ah = 1'b0;
  logic [7:0] std_event = 8'h00, status_byte, lf = 8'h2B;
  logic [32:0] expq[$];
  int fails = 0, n_compared = 0, cyc = 0;
  always #12.5 ref_clk = ~ref_clk;
  sbsr_top DUT (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .std_event(std_event), .queue_nonempty(qne), .queue_single(qs),
    .trig_summary(trg), .user_summary(usr), .oper_summary(opr), .advisory_internal(ai),
    .advisory_host(ah), .srq(srq), .status_byte(status_byte));
  sbsr_queue_model QM (.ref_clk(ref_clk), .nrst(nrst), .push(push), .pop(pop),
    .queue_nonempty(qne), .queue_single(qs));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input logic [7:0] ev, input logic i, input logic h);
    @(posedge ref_clk);
    {std_event, ai, ah} <= {ev, i, h};
    @(posedge ref_clk);
    {std_event, ai, ah} <= 10'h000;
  endtask
  task automatic chk(input logic [7:0] sb, input logic s);
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    cmp({25'h0, status_byte}, {25'h0, sb});
    cmp({32'h0, srq}, {32'h0, s});
  endtask
  // Read answers against oldest note; hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      end_sim();
    end
    if (pready === 1'b1 && pwrite === 1'b0) cmp({pslverr, prdata}, expq.pop_front());
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    chk(8'h00, 1'b0);
    pulse(8'h04, 1'b0, 1'b0);
    chk(8'h00, 1'b0);
    rd(sbsr_pkg::ADDR_SESR, 33'h04);
    apb(1'b1, sbsr_pkg::ADDR_ESE, 32'h04);
    pulse(8'h04, 1'b0, 1'b0);
    chk(8'h20, 1'b0);
    apb(1'b1, sbsr_pkg::ADDR_SRE, 32'hFF);
    rd(sbsr_pkg::ADDR_SRE, 33'hBF);
    apb(1'b1, sbsr_pkg::ADDR_SRE, 32'h30);
    chk(8'h60, 1'b1);
    rd(sbsr_pkg::ADDR_STB, 33'h60);
    rd(sbsr_pkg::ADDR_SESR, 33'h04);
    chk(8'h40, 1'b1);
    rd(sbsr_pkg::ADDR_SPOLL, 33'h40);
    chk(8'h00, 1'b0);
    pulse(8'h04, 1'b0, 1'b0);
    chk(8'h60, 1'b1);
    $display("test request done");
    rd(sbsr_pkg::ADDR_SESR, 33'h04);
    @(posedge ref_clk) push <= 1'b1;
    @(posedge ref_clk) push <= 1'b0;
    rd(sbsr_pkg::ADDR_SPOLL, 33'h50);
    chk(8'h50, 1'b1);
    apb(1'b1, sbsr_pkg::ADDR_SRE, 32'h00);
    rd(sbsr_pkg::ADDR_SPOLL, 33'h50);
    chk(8'h10, 1'b0);
    rd(sbsr_pkg::ADDR_STBQ, 33'h10);
    rd(sbsr_pkg::ADDR_STB, 33'h00);
    @(posedge ref_clk) pop <= 1'b1;
    @(posedge ref_clk) pop <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      lf = lfsr(lf);
      @(posedge ref_clk) {opr, usr, trg} <= lf[2:0];
      chk({lf[2], 4'h0, lf[1:0], 1'b0}, 1'b0);
    end
    @(posedge ref_clk) {opr, usr, trg} <= 3'h0;
    $display("test live done");
    pulse(8'h00, 1'b0, 1'b1);
    chk(8'h00, 1'b0);
    pulse(8'h00, 1'b1, 1'b0);
    chk(8'h08, 1'b0);
    rd(sbsr_pkg::ADDR_ADVEV, 33'h01);
    rd(12'h01C, 33'h1_0000_0000);
    @(posedge ref_clk);
    $display("test advisory done");
    end_sim();
  end
endmodule // status_byte_service_request_tb_top
